// File: ssi_defines.vh
/*
 Serial interface constants: register indices,
 fields, reset values, mode codes, timing.
 Assumes inclusion by its bare name from the serial interface module.
*/
`ifndef SSI_DEFINES_VH
`define SSI_DEFINES_VH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define SSI_ADDR_W          3
`define SSI_A_MODE_CTRL     3'h0
`define SSI_A_AUX_CTRL      3'h1
`define SSI_A_DATA          3'h2
`define SSI_A_TW_STATUS     3'h3
`define SSI_A_TIMEOUT       3'h4

// ----------------------------------------------------------------------
// Mode control fields
// ----------------------------------------------------------------------
`define SSI_MODE_HI         7
`define SSI_MODE_LO         5
`define SSI_DEB_HI          3
`define SSI_DEB_LO          2
`define SSI_EN_BIT          1
`define SSI_ICF_BIT         0
`define SSI_MODE_RST        3'h7

`define SSI_MODE_DIV4       3'h0
`define SSI_MODE_DIV16      3'h1
`define SSI_MODE_DIV64      3'h2
`define SSI_MODE_SUB        3'h3
`define SSI_MODE_TMR        3'h4
`define SSI_MODE_SLAVE      3'h5
`define SSI_MODE_TWOWIRE    3'h6

// ----------------------------------------------------------------------
// Auxiliary control fields
// ----------------------------------------------------------------------
`define SSI_SPARE_HI        7
`define SSI_SPARE_LO        6
`define SSI_CPOL_BIT        5
`define SSI_CLOCK_EDGE_SELECT_BIT        4
`define SSI_MLS_BIT         3
`define SSI_SELECT_PIN_ENABLE_BIT        2
`define SSI_WRITE_COLLISION_FLAG_BIT        1
`define SSI_TRF_BIT         0

// ----------------------------------------------------------------------
// Debounce codes and timing
// ----------------------------------------------------------------------
`define SSI_DEB_NONE        2'h0
`define SSI_DEB_TWO         2'h1
`define SSI_DEB_CNT2        3'h2
`define SSI_DEB_CNT4        3'h4
`define SSI_BITS            4'h8
`define SSI_HALF_DIV4       6'h01
`define SSI_HALF_DIV16      6'h07
`define SSI_HALF_DIV64      6'h1F

`endif

// File: ssi_serial_interface.v
/*
 SPI master/slave shifter with register port,
 two-wire clock debounce and open-drain pins.
 Assumes a 20 MHz core clock, read data one
 cycle after the strobe, and pin muxing that
 takes a pin whenever its output enable is low.
*/
// What this block does
// [R1] Master: data write while enabled starts a full-duplex transfer.
// [R2] Done flag sets on completion, sticky until software clears it.
// [R3] Slave: each master clock edge shifts buffer out and input in.
// [R4] External master asserts select before giving any clock pulses.
// [R5] Slave output bits timed by clock polarity and edge select.
// [R6] Keeps running in idle while its clock source still runs.
// [R7] Slave with select disabled is always active, ignores select pin.
// [R8] Select disabled: pin floats; enabled: pin acts as select.
// [R9] Select and interface enabled: input floats, data output high.
// [R10] Idle master holds clock at the inverse of the polarity level; slave floats clock.
// [R11] Interface disabled releases all pins to other functions.
// [R12] Received bits collect internally, copied to data when complete.
// [R13] Data write during transfer dropped and sets collision flag.
// [R14] Master makes the clock; slave takes clock from external master.
// [R15] Bit order must match the far end of the link.
// [R16] Two-wire data and clock are open-drain with pull-ups.
// [R17] Two-wire role is slave only, transmit and receive; this block's two-wire mode only releases the pins and shifts no data.
// [R18] Two-wire role has no select; address match selects; this block never compares slave_address.
// [R19] Two-wire pull-up control stays under software.
// [R20] Two-wire clock debounced by none, 2 or 4 system clocks.
// [R21] System clock must stay above a minimum for the debounce.
// [R22] Mode field picks master clock, SPI slave or two-wire slave.
// [R23] Select released before byte done sets incomplete and done.
// [R24] Edge select with polarity chooses the capture edge.
// [R25] Debounce code 00 none, 01 two clocks, 1x four clocks.
// [R26] Each transfer moves eight bits; done after last sample.
// [R27] Master clock is a glitch-free enabled division.
`timescale 1ns/1ps
`default_nettype none
`include "ssi_defines.vh"

module ssi_serial_interface #(
   parameter DATA_W = 8
) (
   input  wire                   core_clk,
   input  wire                   rstn,
   input  wire [`SSI_ADDR_W-1:0] reg_addr,
   input  wire [7:0]             reg_wdata,
   input  wire                   reg_wr,
   input  wire                   reg_rd,
   output reg  [7:0]             reg_rdata,
   input  wire                   sub_clk_tick,
   input  wire                   timer_tick,
   input  wire                   sck_in,
   output reg                    sck_out,
   output reg                    sck_oe,
   input  wire                   sdi_in,
   output reg                    sdo_out,
   output reg                    sdo_oe,
   input  wire                   slave_select_n_in,
   output reg                    slave_select_n_out,
   output reg                    slave_select_n_oe,
   output reg                    pins_claimed,
   output reg                    tw_pullup_en,
   output reg                    tw_clk_filtered
);

   // -------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------
   reg  [2:0]        operating_mode_field;
   reg  [1:0]        debounce_select;
   reg               interface_enable;
   reg               incomplete_transfer_flag;
   reg  [1:0]        aux_spare;
   reg               clock_idle_polarity;
   reg               clock_edge_select;
   reg               bit_order_select;
   reg               select_pin_enable;
   reg               write_collision_flag;
   reg               transfer_done_flag;
   reg  [7:0]        data_shift_buffer;
   reg  [7:0]        shift_reg;
   reg  [7:0]        slave_address;
   reg  [7:0]        bus_timeout_control;
   reg  [7:0]        two_wire_status_control;
   reg               busy;
   reg  [3:0]        bit_cnt;
   reg  [5:0]        div_cnt;
   reg               sck_phase;

   // Pin input synchronisers
   reg  [2:0]        sck_sync;
   reg  [2:0]        sdi_sync;
   reg  [2:0]        ss_sync;
   reg               sck_level;
   reg               ss_level;
   reg  [2:0]        deb_cnt;

   wire is_master = (operating_mode_field <= `SSI_MODE_TMR);
   wire is_slave  = (operating_mode_field == `SSI_MODE_SLAVE);
   wire is_tw     = (operating_mode_field == `SSI_MODE_TWOWIRE);
   wire wr_data   = reg_wr && (reg_addr == `SSI_A_DATA);

   // Capture edge choice
   wire capture_rise = (clock_idle_polarity == clock_edge_select); // R24

   function [7:0] ssi_shift_in;
      input [7:0] cur;
      input       msb_first;
      input       bit_in;
      begin
         if (msb_first) begin
            ssi_shift_in = {cur[6:0], bit_in};
         end else begin
            ssi_shift_in = {bit_in, cur[7:1]};
         end
      end
   endfunction

   function ssi_out_bit;
      input [7:0] cur;
      input       msb_first;
      begin
         ssi_out_bit = msb_first ? cur[7] : cur[0];
      end
   endfunction

   // -------------------------------------------------------------------
   // Pin sampling
   // -------------------------------------------------------------------
   always @(posedge core_clk) begin
      if (!rstn) begin
         sck_sync <= 3'h7;
         sdi_sync <= 3'h0;
         ss_sync  <= 3'h7;
         sck_level <= 1'b1;
         ss_level  <= 1'b1;
      end else begin
         sck_sync <= {sck_sync[1:0], sck_in};
         sdi_sync <= {sdi_sync[1:0], sdi_in};
         ss_sync  <= {ss_sync[1:0], slave_select_n_in};
         if (sck_sync[1] == sck_sync[2]) begin
            sck_level <= sck_sync[2];
         end
         if (ss_sync[1] == ss_sync[2]) begin
            ss_level <= ss_sync[2];
         end
      end
   end

   wire sck_edge  = (sck_sync[1] == sck_sync[2]) && (sck_sync[2] != sck_level);
   wire sck_rise  = sck_edge && sck_sync[2];
   wire sck_fall  = sck_edge && !sck_sync[2];
   // Select pin only when enabled
   wire slave_sel = !select_pin_enable || !ss_level; // R7 R8
   wire ss_rise   = (ss_sync[1] == ss_sync[2]) && ss_sync[2] && !ss_level;

   // -------------------------------------------------------------------
   // Two-wire clock debounce
   // -------------------------------------------------------------------
   wire [2:0] deb_need = (debounce_select == `SSI_DEB_NONE) ? 3'h0 :
                         (debounce_select == `SSI_DEB_TWO) ? `SSI_DEB_CNT2 :
                         `SSI_DEB_CNT4; // R25

   always @(posedge core_clk) begin
      if (!rstn) begin
         deb_cnt         <= 3'h0;
         tw_clk_filtered <= 1'b1;
      end else if (sck_sync[2] == tw_clk_filtered) begin
         deb_cnt <= 3'h0;
      end else if (deb_cnt >= deb_need) begin
         tw_clk_filtered <= sck_sync[2]; // R20
         deb_cnt         <= 3'h0;
      end else begin
         deb_cnt <= deb_cnt + 3'h1;
      end
   end

   // -------------------------------------------------------------------
   // Master clock divider
   // -------------------------------------------------------------------
   reg [5:0] half_div;
   always @* begin
      case (operating_mode_field)
         `SSI_MODE_DIV4:  half_div = `SSI_HALF_DIV4;
         `SSI_MODE_DIV16: half_div = `SSI_HALF_DIV16;
         default:         half_div = `SSI_HALF_DIV64;
      endcase
   end

   reg half_tick;
   always @* begin
      if (operating_mode_field == `SSI_MODE_SUB) begin
         half_tick = sub_clk_tick;
      end else if (operating_mode_field == `SSI_MODE_TMR) begin
         half_tick = timer_tick;
      end else begin
         half_tick = (div_cnt == half_div);
      end
   end

   // -------------------------------------------------------------------
   // Shift engine
   // -------------------------------------------------------------------
   wire master_run = is_master && interface_enable && busy;
   // Lead half shifts out, trail half samples
   wire m_lead  = master_run && half_tick && !sck_phase;
   wire m_trail = master_run && half_tick && sck_phase;
   wire sdi_bit = m_trail ? sdi_sync[1] : sdi_sync[2]; // R1
   wire s_act   = is_slave && interface_enable && slave_sel;
   wire s_cap   = s_act && (capture_rise ? sck_rise : sck_fall); // R3 R14
   wire s_drv   = s_act && (capture_rise ? sck_fall : sck_rise); // R5
   wire samp    = m_trail || s_cap;
   wire last    = samp && (bit_cnt == `SSI_BITS - 4'h1); // R26
   wire incompl = is_slave && interface_enable && select_pin_enable &&
                  ss_rise && busy; // R23
   wire reg_a   = reg_wr && (reg_addr == `SSI_A_AUX_CTRL);
   wire reg_m   = reg_wr && (reg_addr == `SSI_A_MODE_CTRL);

   always @(posedge core_clk) begin
      if (!rstn) begin
         busy      <= 1'b0;
         bit_cnt   <= 4'h0;
         div_cnt   <= 6'h00;
         sck_phase <= 1'b0;
         shift_reg <= 8'h00;
         data_shift_buffer <= 8'h00;
      end else begin
         if (!master_run || half_tick) begin
            div_cnt <= 6'h00;
         end else begin
            div_cnt <= div_cnt + 6'h01; // R27
         end
         if (!interface_enable) begin
            busy      <= 1'b0;
            bit_cnt   <= 4'h0;
            sck_phase <= 1'b0;
         end else if (wr_data && !busy) begin
            data_shift_buffer <= reg_wdata;
            shift_reg         <= reg_wdata;
            bit_cnt           <= 4'h0;
            sck_phase         <= 1'b0;
            busy              <= is_master; // R1
         end else if (incompl) begin
            busy    <= 1'b0;
            bit_cnt <= 4'h0;
         end else begin
            if (m_lead) begin
               sck_phase <= 1'b1;
            end else if (m_trail) begin
               sck_phase <= 1'b0;
            end
            if (s_cap && !busy) begin
               busy <= 1'b1;
            end
            if (samp) begin
               shift_reg <= ssi_shift_in(shift_reg, bit_order_select,
                                         sdi_bit); // R15
               bit_cnt   <= bit_cnt + 4'h1;
               if (last) begin
                  data_shift_buffer <= ssi_shift_in(shift_reg,
                     bit_order_select, sdi_bit); // R12
                  busy    <= 1'b0;
                  bit_cnt <= 4'h0;
               end
            end
         end
      end
   end

   // -------------------------------------------------------------------
   // Register writes and flags
   // -------------------------------------------------------------------
   always @(posedge core_clk) begin
      if (!rstn) begin
         operating_mode_field     <= `SSI_MODE_RST;
         debounce_select          <= `SSI_DEB_NONE;
         interface_enable         <= 1'b0;
         incomplete_transfer_flag <= 1'b0;
         aux_spare                <= 2'h0;
         clock_idle_polarity      <= 1'b0;
         clock_edge_select        <= 1'b0;
         bit_order_select         <= 1'b0;
         select_pin_enable        <= 1'b0;
         write_collision_flag     <= 1'b0;
         transfer_done_flag       <= 1'b0;
         slave_address            <= 8'h00;
         bus_timeout_control      <= 8'h00;
         two_wire_status_control  <= 8'h00;
      end else begin
         if (reg_m) begin
            operating_mode_field <= reg_wdata[`SSI_MODE_HI:`SSI_MODE_LO];
            debounce_select      <= reg_wdata[`SSI_DEB_HI:`SSI_DEB_LO];
            interface_enable     <= reg_wdata[`SSI_EN_BIT];
         end
         // Set wins over clear
         if (incompl) begin
            incomplete_transfer_flag <= 1'b1; // R23
         end else if (reg_m) begin
            incomplete_transfer_flag <= reg_wdata[`SSI_ICF_BIT];
         end
         if (reg_a) begin
            aux_spare           <= reg_wdata[`SSI_SPARE_HI:`SSI_SPARE_LO];
            clock_idle_polarity <= reg_wdata[`SSI_CPOL_BIT];
            clock_edge_select   <= reg_wdata[`SSI_CLOCK_EDGE_SELECT_BIT];
            bit_order_select    <= reg_wdata[`SSI_MLS_BIT];
            select_pin_enable   <= reg_wdata[`SSI_SELECT_PIN_ENABLE_BIT];
         end
         if (wr_data && busy) begin
            write_collision_flag <= 1'b1; // R13
         end else if (reg_a) begin
            write_collision_flag <= reg_wdata[`SSI_WRITE_COLLISION_FLAG_BIT];
         end
         if (last || incompl) begin
            transfer_done_flag <= 1'b1; // R2
         end else if (reg_a) begin
            transfer_done_flag <= reg_wdata[`SSI_TRF_BIT];
         end
         if (reg_wr && reg_addr == `SSI_A_TW_STATUS) begin
            two_wire_status_control <= reg_wdata;
         end
         if (reg_wr && reg_addr == `SSI_A_TIMEOUT) begin
            bus_timeout_control <= reg_wdata;
         end
      end
   end

   // -------------------------------------------------------------------
   // Read port
   // -------------------------------------------------------------------
   always @(posedge core_clk) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (!reg_rd) begin
         reg_rdata <= 8'h00;
      end else if (reg_addr == `SSI_A_MODE_CTRL) begin
         reg_rdata <= {operating_mode_field, 1'b0, debounce_select,
                       interface_enable, incomplete_transfer_flag};
      end else if (reg_addr == `SSI_A_AUX_CTRL) begin
         reg_rdata <= {aux_spare, clock_idle_polarity, clock_edge_select,
                       bit_order_select, select_pin_enable,
                       write_collision_flag, transfer_done_flag};
      end else if (reg_addr == `SSI_A_DATA) begin
         reg_rdata <= data_shift_buffer;
      end else if (reg_addr == `SSI_A_TW_STATUS) begin
         reg_rdata <= two_wire_status_control;
      end else if (reg_addr == `SSI_A_TIMEOUT) begin
         reg_rdata <= bus_timeout_control;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // -------------------------------------------------------------------
   // Pin drive
   // -------------------------------------------------------------------
   wire spi_on = interface_enable && !is_tw && (is_master || is_slave);
   always @(posedge core_clk) begin
      if (!rstn) begin
         sck_out            <= 1'b1;
         sck_oe             <= 1'b0;
         sdo_out            <= 1'b1;
         sdo_oe             <= 1'b0;
         slave_select_n_out <= 1'b1;
         slave_select_n_oe  <= 1'b0;
         pins_claimed       <= 1'b0;
         tw_pullup_en       <= 1'b0;
      end else begin
         pins_claimed <= interface_enable && !(operating_mode_field ==
                         `SSI_MODE_RST); // R11 R6
         tw_pullup_en <= two_wire_status_control[0]; // R19
         if (is_tw && interface_enable) begin
            // Open drain, released
            sck_out <= 1'b0; // R16 R17 R18
            sck_oe  <= 1'b0;
            sdo_out <= 1'b0;
            sdo_oe  <= 1'b0;
         end else if (spi_on && is_master) begin
            sck_oe  <= 1'b1; // R14
            sck_out <= master_run ? (clock_idle_polarity ~^ !sck_phase)
                                  : !clock_idle_polarity; // R10
            sdo_oe  <= 1'b1;
            if (!busy) begin
               sdo_out <= 1'b1; // R9
            end else if (m_lead) begin
               sdo_out <= ssi_out_bit(shift_reg, bit_order_select);
            end
         end else if (spi_on) begin
            sck_oe  <= 1'b0; // R10
            sdo_oe  <= slave_sel;
            if (!busy && !s_cap && !s_drv) begin
               sdo_out <= ssi_out_bit(shift_reg, bit_order_select);
            end else if (s_drv) begin
               sdo_out <= ssi_out_bit(shift_reg, bit_order_select); // R5
            end
         end else begin
            sck_oe <= 1'b0; // R11
            sdo_oe <= 1'b0;
         end
         slave_select_n_out <= !(spi_on && is_master && busy);
         slave_select_n_oe  <= spi_on && is_master && select_pin_enable;
      end
   end

endmodule // ssi_serial_interface
`default_nettype wire

// File: ssi_serial_interface_asserts.sv
/*
 Checker on the interface ports.
 Assumes the bind below.
*/
`timescale 1ns/1ps
`default_nettype none
module ssi_asserts (
   input wire logic       core_clk,
   input wire logic       rstn,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       sck_out,
   input wire logic       sck_oe,
   input wire logic       sdo_out,
   input wire logic       sdo_oe,
   input wire logic       slave_select_n_out,
   input wire logic       slave_select_n_oe,
   input wire logic       pins_claimed,
   input wire logic       tw_pullup_en,
   input wire logic       tw_clk_filtered
);
   logic last_pu;

   always @(posedge core_clk) begin
      if (reg_wr && reg_addr == 3'h3) begin
         last_pu <= reg_wdata[0];
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   a_reset_outputs: assert property (disable iff (1'b0) !rstn |=>
      reg_rdata == 8'h00 && !sck_oe && !sdo_oe && !slave_select_n_oe
      && !pins_claimed && tw_clk_filtered)
      else $error("outputs not at reset level");
   a_rdata_window: assert property (!$past(reg_rd) |->
      reg_rdata == 8'h00) else $error("read data outside its slot");
   a_pins_released: assert property (!pins_claimed &&
      !$past(pins_claimed) |-> !sck_oe && !sdo_oe && !slave_select_n_oe)
      else $error("pin driven while released");
   a_sck_half_period: assert property (sck_oe && $past(sck_oe) &&
      $changed(sck_out) |=> $stable(sck_out))
      else $error("sck half period short");
   a_select_busy: assert property (sck_oe && slave_select_n_oe &&
      $changed(sck_out) |-> !slave_select_n_out
      || !$past(slave_select_n_out))
      else $error("clock edge without select");
   a_pullup_copy: assert property (reg_wr && reg_addr == 3'h3
      |=> ##1 tw_pullup_en == last_pu)
      else $error("pull-up not following register");
   a_status_readback: assert property (reg_wr && reg_addr == 3'h3
      ##1 reg_rd && reg_addr == 3'h3 |=> reg_rdata == $past(reg_wdata, 2))
      else $error("status readback wrong");
   a_sdo_idle_high: assert property (sdo_oe && sck_oe &&
      slave_select_n_oe && slave_select_n_out && $past(slave_select_n_out)
      |-> sdo_out) else $error("idle data output not high");
endmodule // ssi_asserts

bind ssi_serial_interface ssi_asserts u_ssi_asserts (.*);
`default_nettype wire

// File: ssi_spi_slave_model.sv
/*
 SPI slave facing the block in master mode.
 Assumes idle-high clock, rising capture, MSB first.
*/
`timescale 1ns/1ps
`default_nettype none
module ssi_spi_slave_model (
   input  wire logic       sck,
   input  wire logic       sel_n,
   input  wire logic       mosi,
   input  wire logic [7:0] tx_byte,
   output logic            miso,
   output logic [7:0]      rx_byte
);
   logic [7:0] tx_sr;

   initial begin
      miso = 1'b0;
      rx_byte = 8'h00;
      tx_sr = 8'h00;
   end
   always @(negedge sel_n) begin
      tx_sr = tx_byte;
   end
   // Released line shows the inverse
   always @(posedge sel_n) begin
      miso = ~miso;
   end
   always @(negedge sck) begin
      // First fall meets select; let the load settle
      #1;
      if (!sel_n) begin
         miso = tx_sr[7];
         tx_sr = {tx_sr[6:0], 1'b0};
      end
   end
   always @(posedge sck) begin
      if (!sel_n) begin
         rx_byte = {rx_byte[6:0], mosi};
      end
   end
endmodule // ssi_spi_slave_model
`default_nettype wire

// File: ssi_serial_interface_tb_top.sv
/*
 Self-checking bench: registers, master, slave and two-wire filter.
 Assumes the checker is bound from its own file.
*/
`timescale 1ns/1ps
`default_nettype none
module ssi_serial_interface_tb_top;
   logic       core_clk, rstn, reg_wr, reg_rd, sck_in, tb_sdi, sel_n_in;
   logic       use_m;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, d, m_tx;
   wire  [7:0] reg_rdata, m_rx;
   wire        sck_out, sck_oe, sdo_out, sdo_oe, ss_n_out, ss_n_oe;
   wire        pins_claimed, tw_pullup_en, tw_filt, m_miso;
   wire        sdi = use_m ? m_miso : tb_sdi;
   int         miscompares, num_checks, cycles;

   ssi_serial_interface u_ssi_serial_interface (.core_clk(core_clk),
      .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sub_clk_tick(1'b0), .timer_tick(1'b0), .sck_in(sck_in),
      .sck_out(sck_out), .sck_oe(sck_oe), .sdi_in(sdi),
      .sdo_out(sdo_out), .sdo_oe(sdo_oe), .slave_select_n_in(sel_n_in),
      .slave_select_n_out(ss_n_out), .slave_select_n_oe(ss_n_oe),
      .pins_claimed(pins_claimed), .tw_pullup_en(tw_pullup_en),
      .tw_clk_filtered(tw_filt));
   ssi_spi_slave_model u_ssi_spi_slave_model (.sck(sck_out),
      .sel_n(ss_n_oe ? ss_n_out : 1'b1), .mosi(sdo_out), .tx_byte(m_tx),
      .miso(m_miso), .rx_byte(m_rx));

   // ---------------------------------------------------------------
   // Clock, timeout, tasks
   // ---------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         report_and_stop;
      end
   end
   task report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task chk(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [2:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      d = reg_rdata;
   endtask
   task wait_done;
      for (int k = 0; k < 300; k++) begin
         rd(3'h1);
         if (d[0] === 1'b1) break;
      end
   endtask
   task slv(input logic [7:0] mi, input logic [7:0] so, input int n,
            input logic sel);
      logic [7:0] g;
      @(posedge core_clk);
      sel_n_in <= !sel;
      repeat (4) @(posedge core_clk);
      for (int i = 0; i < n; i++) begin
         sck_in <= 1'b0;
         tb_sdi <= mi[7-i];
         repeat (4) @(posedge core_clk);
         sck_in <= 1'b1;
         repeat (2) @(posedge core_clk);
         @(negedge core_clk);
         g[7-i] = sdo_out;
         repeat (2) @(posedge core_clk);
      end
      tb_sdi <= ~tb_sdi;
      repeat (4) @(posedge core_clk);
      sel_n_in <= 1'b1;
      repeat (8) @(posedge core_clk);
      if (n == 8) chk(g, so);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task t_regs;
      rd(3'h0); chk(d, 8'hE0);
      rd(3'h1); chk(d, 8'h00);
      rd(3'h5); chk(d, 8'h00);
      wr(3'h4, 8'h5A); rd(3'h4); chk(d, 8'h5A);
      $display("test regs done");
   endtask
   task t_master;
      logic [7:0] x;
      wr(3'h1, 8'h0C);
      for (int m = 0; m < 3; m++) begin
         m_tx = 8'hA5 ^ m[7:0];
         x = 8'h3C + m[7:0];
         wr(3'h0, {m[2:0], 5'b00010});
         wr(3'h2, x);
         wr(3'h2, 8'hFF);
         wait_done;
         chk(d & 8'h03, 8'h03);
         rd(3'h2); chk(d, 8'hA5 ^ m[7:0]);
         chk(m_rx, x);
         wr(3'h1, 8'h0C); rd(3'h1); chk(d, 8'h0C);
      end
      chk({sdo_out, ss_n_out}, 8'h03);
      wr(3'h1, 8'h28); rd(3'h1);
      chk({sck_out, sck_oe, ss_n_oe}, 8'h02);
      wr(3'h0, 8'h00); rd(3'h0);
      chk({pins_claimed, sck_oe, sdo_oe, ss_n_oe}, 8'h00);
      $display("test master done");
   endtask
   task t_slave;
      @(posedge core_clk);
      use_m <= 1'b0;
      wr(3'h1, 8'h0C); wr(3'h0, 8'hA2); wr(3'h2, 8'h96);
      slv(8'h5A, 8'h96, 8, 1'b1);
      rd(3'h1); chk(d & 8'h01, 8'h01);
      rd(3'h2); chk(d, 8'h5A);
      wr(3'h1, 8'h0C); wr(3'h2, 8'h11);
      slv(8'h00, 8'h00, 3, 1'b1);
      rd(3'h0); chk(d & 8'h01, 8'h01);
      rd(3'h1); chk(d & 8'h01, 8'h01);
      wr(3'h0, 8'hA2); wr(3'h1, 8'h00); rd(3'h1);
      chk(ss_n_oe, 1'b0);
      wr(3'h2, 8'h06);
      slv(8'h01, 8'h60, 8, 1'b0);
      rd(3'h2); chk(d, 8'h80);
      $display("test slave done");
   endtask
   task t_tw;
      logic dip;
      logic [1:0] c;
      for (int k = 0; k < 4; k++) begin
         c = k[1:0];
         wr(3'h0, {3'b110, 1'b0, c, 2'b10});
         dip = 1'b0;
         if (c != 2'b00) begin
            @(posedge core_clk);
            sck_in <= 1'b0;
            repeat (c == 2'b01 ? 1 : 2) @(posedge core_clk);
            sck_in <= 1'b1;
            repeat (10) begin
               @(negedge core_clk);
               if (tw_filt !== 1'b1) dip = 1'b1;
            end
            chk(dip, 1'b0);
         end
         @(posedge core_clk);
         sck_in <= 1'b0;
         repeat (12) @(posedge core_clk);
         @(negedge core_clk); chk(tw_filt, 1'b0);
         @(posedge core_clk);
         sck_in <= 1'b1;
         repeat (12) @(posedge core_clk);
         @(negedge core_clk); chk(tw_filt, 1'b1);
         chk({sdo_oe, sck_oe}, 8'h00);
      end
      for (int k = 1; k >= 0; k--) begin
         @(posedge core_clk);
         reg_addr <= 3'h3;
         reg_wdata <= k[7:0];
         reg_wr <= 1'b1;
         @(posedge core_clk);
         reg_wr <= 1'b0;
         reg_rd <= 1'b1;
         @(posedge core_clk);
         reg_rd <= 1'b0;
         @(negedge core_clk); chk(reg_rdata, k[7:0]);
         repeat (2) @(posedge core_clk);
         @(negedge core_clk); chk(tw_pullup_en, k[0]);
      end
      $display("test two-wire done");
   endtask

   initial begin
      rstn = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      sck_in = 1'b1;
      tb_sdi = 1'b0;
      sel_n_in = 1'b1;
      use_m = 1'b1;
      m_tx = 8'h00;
      repeat (5) @(posedge core_clk);
      rstn <= 1'b1;
      t_regs;
      t_master;
      t_slave;
      t_tw;
      report_and_stop;
   end
endmodule // ssi_serial_interface_tb_top
`default_nettype wire
